// ### hw/core_local_pin_io_registers.sv
// Purpose: Core-local pin level and drive-enable registers with atomic aliases.
// Assumes: Core 0 and core 1 each own one AXI4-Lite port; pins are synchronous to aclk.
// Notes: Read answers arrive one cycle after the address is taken.
//
// Implementation choice: register access over AXI4-Lite.
module core_local_pin_io_registers import core_local_io_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire axil_req_t [CORE_N-1:0] core_req,
  output axil_rsp_t [CORE_N-1:0] core_rsp,
  input wire logic [PIN_N-1:0] pin_in,
  input wire logic [FLASH_N-1:0] flash_pin_in,
  output logic [PIN_N-1:0] pin_out,
  output logic [PIN_N-1:0] pin_oe
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [PIN_N-1:0] out_reg, out_next;
  logic [PIN_N-1:0] oe_reg, oe_next;
  wr_t wr [CORE_N];
  logic [ADDR_W-1:0] rd_addr [CORE_N];
  logic [DATA_W-1:0] rd_data [CORE_N];
  logic rd_err [CORE_N];
  logic wr_err [CORE_N];

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == OFF_CORE_ID) || (a == OFF_PIN_IN) || (a == OFF_FLASH_IN) ||
             ((a >= OFF_OUT) && (a <= OFF_OE_XOR));
  endfunction : mapped

  // Applies one core's write to a base register or its aliases. Bits 31:30
  // are dropped here, so reserved bits never store anything.
  function automatic logic [PIN_N-1:0] apply_wr(input logic [PIN_N-1:0] cur,
                                                input wr_t w,
                                                input logic [ADDR_W-1:0] base);
    logic [PIN_N-1:0] m;
    logic [PIN_N-1:0] d;
    m = w.mask[PIN_N-1:0];
    d = w.data[PIN_N-1:0] & m;
    apply_wr = cur;
    if (w.en) begin
      if (w.addr == base) begin
        apply_wr = (cur & ~m) | d;
      end else if (w.addr == base + ALIAS_SET) begin
        apply_wr = cur | d;
      end else if (w.addr == base + ALIAS_CLR) begin
        apply_wr = cur & ~d;
      end else if (w.addr == base + ALIAS_XOR) begin
        apply_wr = cur ^ d;
      end
    end
  endfunction : apply_wr

  // ****************************************************************
  // Per-core ports and read decode
  // ****************************************************************
  for (genvar c = 0; c < CORE_N; c++) begin : g_core
    axil_port_slave u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus_req(core_req[c]),
      .bus_rsp(core_rsp[c]),
      .wr(wr[c]),
      .rd_addr(rd_addr[c]),
      .rd_data(rd_data[c]),
      .rd_err(rd_err[c]),
      .wr_err(wr_err[c])
    );

    assign wr_err[c] = ~mapped(wr[c].addr);

    // Write-only aliases read back as zero rather than erroring.
    always_comb begin
      rd_err[c] = 1'b0;
      case (rd_addr[c])
        OFF_CORE_ID: rd_data[c] = DATA_W'(c);
        OFF_PIN_IN: rd_data[c] = DATA_W'(pin_in);
        OFF_FLASH_IN: rd_data[c] = DATA_W'(flash_pin_in);
        OFF_OUT: rd_data[c] = DATA_W'(out_reg);
        OFF_OE: rd_data[c] = DATA_W'(oe_reg);
        default: begin
          rd_data[c] = '0;
          rd_err[c] = ~mapped(rd_addr[c]);
        end
      endcase
    end
  end

  // ****************************************************************
  // Output level and drive enable update
  // ****************************************************************
  // Core 0 is folded in first and core 1 on its result, which gives the
  // documented ordering for any mix of base and alias writes.
  always_comb begin
    out_next = out_reg;
    oe_next = oe_reg;
    for (int c = 0; c < CORE_N; c++) begin
      out_next = apply_wr(out_next, wr[c], OFF_OUT);
      oe_next = apply_wr(oe_next, wr[c], OFF_OE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= OUT_RESET;
      oe_reg <= OE_RESET;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign pin_out = out_reg;
  assign pin_oe = oe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic solo0;
  logic full0;
  logic [PIN_N-1:0] d0;
  assign solo0 = wr[0].en & ~wr[1].en;
  assign full0 = &wr[0].mask;
  assign d0 = wr[0].data[PIN_N-1:0] & wr[0].mask[PIN_N-1:0];

  // Core 1 twins of the helpers above, so that every alias is also
  // watched when the second core is the only writer.
  logic solo1;
  logic [PIN_N-1:0] d1;
  assign solo1 = wr[1].en & ~wr[0].en;
  assign d1 = wr[1].data[PIN_N-1:0] & wr[1].mask[PIN_N-1:0];

  sequence s_rd0(logic [ADDR_W-1:0] a);
    core_req[0].arvalid && core_rsp[0].arready && (core_req[0].araddr == a);
  endsequence

  sequence s_rd1(logic [ADDR_W-1:0] a);
    core_req[1].arvalid && core_rsp[1].arready && (core_req[1].araddr == a);
  endsequence

  sequence s_solo0(logic [ADDR_W-1:0] a);
    solo0 && (wr[0].addr == a);
  endsequence

  sequence s_solo1(logic [ADDR_W-1:0] a);
    solo1 && (wr[1].addr == a);
  endsequence

  sequence s_dual(logic [ADDR_W-1:0] a0, logic [ADDR_W-1:0] a1);
    wr[0].en && wr[1].en && (wr[0].addr == a0) && (wr[1].addr == a1);
  endsequence

  a_core_id_zero: assert property (s_rd0(OFF_CORE_ID) |=>
    core_rsp[0].rvalid && (core_rsp[0].rdata == 32'h0000_0000))
    else $error("core 0 identifier read wrong");
  a_core_id_one: assert property (s_rd1(OFF_CORE_ID) |=>
    core_rsp[1].rvalid && (core_rsp[1].rdata == 32'h0000_0001))
    else $error("core 1 identifier read wrong");
  a_pin_in_read: assert property (s_rd0(OFF_PIN_IN) |=>
    core_rsp[0].rdata == DATA_W'($past(pin_in)))
    else $error("pin input read wrong");
  a_flash_in_read: assert property (s_rd1(OFF_FLASH_IN) |=>
    core_rsp[1].rdata == DATA_W'($past(flash_pin_in)))
    else $error("flash pin input read wrong");
  a_out_reset_zero: assert property (disable iff (1'b0) !aresetn |=>
    (pin_out == OUT_RESET))
    else $error("output level not cleared by reset");
  a_oe_reset_zero: assert property (disable iff (1'b0) !aresetn |=>
    (pin_oe == OE_RESET))
    else $error("drive enable not cleared by reset");
  a_out_readback: assert property (s_rd0(OFF_OUT) |=>
    core_rsp[0].rdata == DATA_W'($past(pin_out)))
    else $error("output level readback wrong");
  a_oe_readback: assert property (s_rd1(OFF_OE) |=>
    core_rsp[1].rdata == DATA_W'($past(pin_oe)))
    else $error("drive enable readback wrong");
  a_dual_write_order: assert property (s_dual(OFF_OUT_SET, OFF_OUT_CLR) |=>
    pin_out == (($past(pin_out) | $past(d0)) & ~$past(d1)))
    else $error("core 1 write not applied after core 0");
  a_out_set_or: assert property (s_solo0(OFF_OUT_SET) |=>
    pin_out == ($past(pin_out) | $past(d0)))
    else $error("output set alias wrong");
  a_out_clear_bits: assert property (s_solo0(OFF_OUT_CLR) |=>
    pin_out == ($past(pin_out) & ~$past(d0)))
    else $error("output clear alias wrong");
  a_out_toggle_bits: assert property (s_solo0(OFF_OUT_XOR) |=>
    pin_out == ($past(pin_out) ^ $past(d0)))
    else $error("output toggle alias wrong");
  a_oe_set_or: assert property (s_solo0(OFF_OE_SET) |=>
    pin_oe == ($past(pin_oe) | $past(d0)))
    else $error("enable set alias wrong");
  a_oe_clear_bits: assert property (s_solo0(OFF_OE_CLR) |=>
    pin_oe == ($past(pin_oe) & ~$past(d0)))
    else $error("enable clear alias wrong");
  a_oe_toggle_bits: assert property (s_solo0(OFF_OE_XOR) |=>
    pin_oe == ($past(pin_oe) ^ $past(d0)))
    else $error("enable toggle alias wrong");
  a_reserved_zero: assert property (core_rsp[0].rvalid |->
    (core_rsp[0].rdata[DATA_W-1:PIN_N] == 2'h0))
    else $error("reserved read bits not zero");

  // ****************************************************************
  // Checks mirrored onto the other core
  // ****************************************************************
  // The ports are copies of one another, but the read mux and the fold
  // order are not, so each core gets its own set of checks.
  a_reserved_one: assert property (core_rsp[1].rvalid |->
    (core_rsp[1].rdata[DATA_W-1:PIN_N] == 2'h0))
    else $error("reserved read bits not zero on core 1");
  a_pin_in_one: assert property (s_rd1(OFF_PIN_IN) |=>
    core_rsp[1].rdata == DATA_W'($past(pin_in)))
    else $error("pin input read wrong on core 1");
  a_flash_in_zero: assert property (s_rd0(OFF_FLASH_IN) |=>
    core_rsp[0].rdata == DATA_W'($past(flash_pin_in)))
    else $error("flash pin input read wrong on core 0");
  a_out_readback_one: assert property (s_rd1(OFF_OUT) |=>
    core_rsp[1].rdata == DATA_W'($past(pin_out)))
    else $error("output level readback wrong on core 1");
  a_oe_readback_zero: assert property (s_rd0(OFF_OE) |=>
    core_rsp[0].rdata == DATA_W'($past(pin_oe)))
    else $error("drive enable readback wrong on core 0");
  a_out_set_one: assert property (s_solo1(OFF_OUT_SET) |=>
    pin_out == ($past(pin_out) | $past(d1)))
    else $error("output set alias wrong on core 1");
  a_out_clear_one: assert property (s_solo1(OFF_OUT_CLR) |=>
    pin_out == ($past(pin_out) & ~$past(d1)))
    else $error("output clear alias wrong on core 1");
  a_out_toggle_one: assert property (s_solo1(OFF_OUT_XOR) |=>
    pin_out == ($past(pin_out) ^ $past(d1)))
    else $error("output toggle alias wrong on core 1");
  a_oe_set_one: assert property (s_solo1(OFF_OE_SET) |=>
    pin_oe == ($past(pin_oe) | $past(d1)))
    else $error("enable set alias wrong on core 1");
  a_oe_clear_one: assert property (s_solo1(OFF_OE_CLR) |=>
    pin_oe == ($past(pin_oe) & ~$past(d1)))
    else $error("enable clear alias wrong on core 1");
  a_oe_toggle_one: assert property (s_solo1(OFF_OE_XOR) |=>
    pin_oe == ($past(pin_oe) ^ $past(d1)))
    else $error("enable toggle alias wrong on core 1");

  // ****************************************************************
  // Base writes, ordering and ignored writes
  // ****************************************************************
  // A base write only replaces the lanes its strobes select; the rest of
  // the register must survive, or a byte write would wipe other pins.
  a_out_base_zero: assert property (s_solo0(OFF_OUT) |=>
    pin_out == (($past(pin_out) & ~$past(wr[0].mask[PIN_N-1:0])) | $past(d0)))
    else $error("output level base write wrong");
  a_oe_base_zero: assert property (s_solo0(OFF_OE) |=>
    pin_oe == (($past(pin_oe) & ~$past(wr[0].mask[PIN_N-1:0])) | $past(d0)))
    else $error("drive enable base write wrong");
  a_out_base_one: assert property (s_solo1(OFF_OUT) |=>
    pin_out == (($past(pin_out) & ~$past(wr[1].mask[PIN_N-1:0])) | $past(d1)))
    else $error("output level base write wrong on core 1");
  a_oe_base_one: assert property (s_solo1(OFF_OE) |=>
    pin_oe == (($past(pin_oe) & ~$past(wr[1].mask[PIN_N-1:0])) | $past(d1)))
    else $error("drive enable base write wrong on core 1");
  a_dual_oe_order: assert property (s_dual(OFF_OE, OFF_OE_XOR) |=>
    pin_oe == ((($past(pin_oe) & ~$past(wr[0].mask[PIN_N-1:0])) | $past(d0)) ^
               $past(d1)))
    else $error("core 1 enable write not applied after core 0");
  a_out_idle_hold: assert property (!wr[0].en && !wr[1].en |=>
    $stable(pin_out))
    else $error("output level changed without a write");
  a_oe_idle_hold: assert property (!wr[0].en && !wr[1].en |=>
    $stable(pin_oe))
    else $error("drive enable changed without a write");
  a_ro_write_ignored: assert property (s_solo0(OFF_PIN_IN) |=>
    $stable(pin_out) && $stable(pin_oe))
    else $error("write to input register changed state");
  a_flash_write_ignored: assert property (s_solo1(OFF_FLASH_IN) |=>
    $stable(pin_out) && $stable(pin_oe))
    else $error("write to flash input register changed state");
  a_bad_write_ignored: assert property (solo1 && wr_err[1] |=>
    $stable(pin_out) && $stable(pin_oe))
    else $error("write to unmapped address changed state");
  a_out_alias_read: assert property (s_rd1(OFF_OUT_SET) |=>
    core_rsp[1].rdata == 32'h0000_0000)
    else $error("output set alias did not read zero");
  a_oe_alias_read: assert property (s_rd1(OFF_OE_SET) |=>
    core_rsp[1].rdata == 32'h0000_0000)
    else $error("enable set alias did not read zero");

endmodule : core_local_pin_io_registers

// ### hw/core_local_io_pkg.sv
// Purpose: Shared constants and carriers for the core-local pin I/O register block.
// Assumes: AXI4-Lite register ports with 32-bit data and 12-bit byte addresses.
// Notes: Offsets are byte addresses; every register takes one aligned word.
package core_local_io_pkg;

  // ****************************************************************
  // Widths and register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIN_N = 30;
  localparam int FLASH_N = 6;
  localparam int CORE_N = 2;

  localparam logic [ADDR_W-1:0] OFF_CORE_ID = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_PIN_IN = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_FLASH_IN = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_OUT = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_OUT_SET = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_OUT_CLR = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_OUT_XOR = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_OE = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_OE_SET = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_OE_CLR = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_OE_XOR = 12'h02c;

  // Alias distances from a base register.
  localparam logic [ADDR_W-1:0] ALIAS_SET = 12'h004;
  localparam logic [ADDR_W-1:0] ALIAS_CLR = 12'h008;
  localparam logic [ADDR_W-1:0] ALIAS_XOR = 12'h00c;

  localparam logic [PIN_N-1:0] OUT_RESET = 30'h0000_0000;
  localparam logic [PIN_N-1:0] OE_RESET = 30'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // One-cycle write strobe handed from a port to the register core.
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] mask;
  } wr_t;

endpackage : core_local_io_pkg

// ### hw/axil_port_slave.sv
// Purpose: AXI4-Lite slave for one core's register port.
// Assumes: Register core decodes addresses combinationally.
// Notes: Write address and data are held independently; one write and one read in flight.
module axil_port_slave import core_local_io_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire axil_req_t bus_req,
  output axil_rsp_t bus_rsp,
  output wr_t wr,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err
);

  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic do_wr;

  // The write is applied only once the previous response has been taken,
  // so a second write never overruns a pending answer.
  assign do_wr = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign rd_addr = {bus_req.araddr[ADDR_W-1:2], 2'h0};

  always_comb begin
    wr.en = do_wr;
    wr.addr = awaddr_reg;
    wr.data = wdata_reg;
    for (int b = 0; b < 4; b++) begin
      wr.mask[8*b +: 8] = {8{wstrb_reg[b]}};
    end
  end

  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (bus_req.awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = {bus_req.awaddr[ADDR_W-1:2], 2'h0};
    end
    if (bus_req.wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = bus_req.wdata;
      wstrb_next = bus_req.wstrb;
    end
    if (do_wr) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_reg && bus_req.bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = ~aw_held_next;
    wready_next = ~w_held_next;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (bus_req.arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next = rd_data;
      rresp_next = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_reg && bus_req.rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = ~rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  always_comb begin
    bus_rsp.awready = awready_reg;
    bus_rsp.wready = wready_reg;
    bus_rsp.bvalid = bvalid_reg;
    bus_rsp.bresp = bresp_reg;
    bus_rsp.arready = arready_reg;
    bus_rsp.rvalid = rvalid_reg;
    bus_rsp.rdata = rdata_reg;
    bus_rsp.rresp = rresp_reg;
  end

endmodule : axil_port_slave

// ### verif/core_pair_model.sv
// Purpose: Behavioural pair of processor cores acting as AXI4-Lite masters on the block.
// Assumes: Each core drives only its own request slot, right after a rising edge.
// Notes: Response ready lines stay high, so an answer is taken at the edge it is seen.
module core_pair_model import core_local_io_pkg::*; (
  input wire logic aclk,
  output axil_req_t [CORE_N-1:0] core_req,
  input wire axil_rsp_t [CORE_N-1:0] core_rsp
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    core_req = '0;
    for (int c = 0; c < CORE_N; c++) begin
      core_req[c].bready = 1'b1;
      core_req[c].rready = 1'b1;
    end
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Released payload shows its inverse, so a slave that samples late is caught.
  task automatic write(input int c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [3:0] s, output logic [1:0] resp);
    core_req[c].awvalid <= 1'b1;
    core_req[c].awaddr <= a;
    core_req[c].wvalid <= 1'b1;
    core_req[c].wdata <= d;
    core_req[c].wstrb <= s;
    do begin
      @(posedge aclk);
      if (core_req[c].awvalid && core_rsp[c].awready) begin
        core_req[c].awvalid <= 1'b0;
        core_req[c].awaddr <= ~a;
      end
      if (core_req[c].wvalid && core_rsp[c].wready) begin
        core_req[c].wvalid <= 1'b0;
        core_req[c].wdata <= ~d;
      end
    end while (!core_rsp[c].bvalid);
    resp = core_rsp[c].bresp;
  endtask : write

  task automatic read(input int c, input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic [1:0] resp);
    core_req[c].arvalid <= 1'b1;
    core_req[c].araddr <= a;
    do begin
      @(posedge aclk);
      if (core_req[c].arvalid && core_rsp[c].arready) begin
        core_req[c].arvalid <= 1'b0;
        core_req[c].araddr <= ~a;
      end
    end while (!core_rsp[c].rvalid);
    d = core_rsp[c].rdata;
    resp = core_rsp[c].rresp;
  endtask : read

endmodule : core_pair_model

// ### verif/tb_core_local_pin_io_registers.sv
// Purpose: Self-checking bench for the core-local pin register block.
// Assumes: Both cores are modelled by core_pair_model; pins are driven here.
// Notes: Expected values are worked out by hand from the register behaviour.
module tb_core_local_pin_io_registers import core_local_io_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [PIN_N-1:0] pin_in = '0;
  logic [FLASH_N-1:0] flash_pin_in = '0;
  logic [PIN_N-1:0] pin_out;
  logic [PIN_N-1:0] pin_oe;
  axil_req_t [CORE_N-1:0] core_req;
  axil_rsp_t [CORE_N-1:0] core_rsp;
  int n_errors = 0;
  int checks_done = 0;
  logic [ADDR_W-1:0] b;

  always #50 aclk = ~aclk;

  core_local_pin_io_registers u_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .core_req(core_req),
    .core_rsp(core_rsp),
    .pin_in(pin_in),
    .flash_pin_in(flash_pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  core_pair_model u_cores (
    .aclk(aclk),
    .core_req(core_req),
    .core_rsp(core_rsp)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input int c, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    u_cores.write(c, a, d, 4'hf, r);
    check(32'(r), 32'(er));
  endtask : wr

  task automatic rdc(input int c, input logic [ADDR_W-1:0] a, input logic [1:0] er,
                     input logic [31:0] exp);
    logic [1:0] r;
    logic [31:0] d;
    u_cores.read(c, a, d, r);
    check(32'(r), 32'(er));
    check(d, exp);
  endtask : rdc

  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // A full pass needs little more than a hundred cycles; this bound leaves wide margin.
  initial begin
    repeat (3000) @(posedge aclk);
    n_errors++;
    complete_run();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(pin_out), 32'h0000_0000);
    check(32'(pin_oe), 32'h0000_0000);
    rdc(0, OFF_OUT, RESP_OKAY, 32'h0000_0000);
    rdc(1, OFF_OE, RESP_OKAY, 32'h0000_0000);
    fork
      rdc(0, OFF_CORE_ID, RESP_OKAY, 32'h0000_0000);
      rdc(1, OFF_CORE_ID, RESP_OKAY, 32'h0000_0001);
    join
    pin_in <= 30'h2AAA_5555;
    rdc(0, OFF_PIN_IN, RESP_OKAY, 32'h2AAA_5555);
    pin_in <= 30'h1555_AAAA;
    rdc(1, OFF_PIN_IN, RESP_OKAY, 32'h1555_AAAA);
    for (int i = 0; i < FLASH_N; i++) begin
      flash_pin_in <= 6'(1 << i);
      rdc(i % 2, OFF_FLASH_IN, RESP_OKAY, 32'(1 << i));
    end
    pin_in <= 30'h0000_0000;
    for (int k = 0; k < 2; k++) begin
      b = k ? OFF_OE : OFF_OUT;
      wr(k, b, 32'hFFFF_0F0F, RESP_OKAY);
      rdc(0, b, RESP_OKAY, 32'h3FFF_0F0F);
      wr(1, b + ALIAS_SET, 32'h0000_F0F0, RESP_OKAY);
      rdc(0, b, RESP_OKAY, 32'h3FFF_FFFF);
      wr(0, b + ALIAS_CLR, 32'h2000_00FF, RESP_OKAY);
      rdc(1, b, RESP_OKAY, 32'h1FFF_FF00);
      wr(1, b + ALIAS_XOR, 32'hC000_0F01, RESP_OKAY);
      rdc(0, b, RESP_OKAY, 32'h1FFF_F001);
      check(32'(k ? pin_oe : pin_out), 32'h1FFF_F001);
      rdc(1, b + ALIAS_SET, RESP_OKAY, 32'h0000_0000);
    end
    wr(0, OFF_OUT, 32'h0000_0000, RESP_OKAY);
    rdc(1, OFF_OUT, RESP_OKAY, 32'h0000_0000);
    fork
      wr(0, OFF_OUT_SET, 32'h0000_00FF, RESP_OKAY);
      wr(1, OFF_OUT_CLR, 32'h0000_0F0F, RESP_OKAY);
    join
    rdc(0, OFF_OUT, RESP_OKAY, 32'h0000_00F0);
    fork
      wr(0, OFF_OE, 32'h0000_1234, RESP_OKAY);
      wr(1, OFF_OE_XOR, 32'h0000_00FF, RESP_OKAY);
    join
    rdc(1, OFF_OE, RESP_OKAY, 32'h0000_12CB);
    check(32'(pin_oe), 32'h0000_12CB);
    rdc(0, 12'h00c, RESP_SLVERR, 32'h0000_0000);
    wr(1, 12'h030, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(0, OFF_PIN_IN, 32'hFFFF_FFFF, RESP_OKAY);
    wr(1, OFF_FLASH_IN, 32'hFFFF_FFFF, RESP_OKAY);
    check(32'(pin_oe), 32'h0000_12CB);
    check(32'(pin_out), 32'h0000_00F0);
    rdc(1, OFF_PIN_IN, RESP_OKAY, 32'h0000_0000);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(pin_out), 32'h0000_0000);
    check(32'(pin_oe), 32'h0000_0000);
    complete_run();
  end

endmodule : tb_core_local_pin_io_registers
